/* File: design/caf_pkg.sv */
/*
 Package for the core state block: register indexes, flag layout,
 reset values, program counter steps and the carrier structs.
 Assumes a single core clock and an 8-bit datapath around it.
*/
package caf_pkg;

   // Register indexes; byte address on the bus is four times the index
   localparam logic [7:0] IDX_LOW_POINTER   = 8'h83;
   localparam logic [7:0] IDX_BANK_POINTER  = 8'h84;
   localparam logic [7:0] IDX_PROGRAM_FLAGS = 8'h86;
   localparam logic [7:0] IDX_IP_LOW        = 8'hce;
   localparam logic [7:0] IDX_IP_HIGH       = 8'hcf;
   localparam logic [7:0] IDX_INDIRECT      = 8'he7;

   // Flag register fields
   localparam int FLG_CAUSE_HI = 7;
   localparam int FLG_CAUSE_LO = 6;
   localparam int FLG_HVD      = 5;
   localparam int FLG_LVD      = 4;
   localparam int FLG_CARRY    = 2;
   localparam int FLG_NIBBLE   = 1;
   localparam int FLG_ZERO     = 0;

   // Reset cause codes
   localparam logic [1:0] CAUSE_WATCHDOG = 2'b00;
   localparam logic [1:0] CAUSE_LOW_VOLT = 2'b10;
   localparam logic [1:0] CAUSE_PIN      = 2'b11;

   // Reset values and steps
   localparam logic [9:0] IP_RESET     = 10'h000;
   localparam logic [9:0] IP_STEP      = 10'h001;
   localparam logic [9:0] IP_SKIP_STEP = 10'h002;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   localparam logic [7:0] BYTE_FULL    = 8'hff;

   // Program counter operation, one per executed instruction
   typedef enum logic [6:0] {
      CAF_IP_HOLD     = 7'b0000001,
      CAF_IP_NEXT     = 7'b0000010,
      CAF_IP_SKIP     = 7'b0000100,
      CAF_IP_JUMP     = 7'b0001000,
      CAF_IP_LOW_MOVE = 7'b0010000,
      CAF_IP_LOW_ADD  = 7'b0100000,
      CAF_IP_LOW_SUB  = 7'b1000000
   } caf_ip_op_t;

   // Skip condition families
   typedef enum logic [4:0] {
      CAF_SK_COMPARE   = 5'b00001,
      CAF_SK_INCREMENT = 5'b00010,
      CAF_SK_DECREMENT = 5'b00100,
      CAF_SK_BIT_CLEAR = 5'b01000,
      CAF_SK_BIT_SET   = 5'b10000
   } caf_skip_t;

   // Request from decoder and ALU, sampled every cycle
   typedef struct packed {
      caf_ip_op_t ip_op;
      caf_skip_t  skip;
      logic [9:0] jump_addr;
      logic       add_carry_in;
      logic [7:0] operand;
      logic [7:0] dest_old;
      logic       tested_bit;
      logic       acc_we;
      logic [7:0] acc_wdata;
      logic       alu_flag_we;
      logic [7:0] alu_result;
      logic       alu_carry;
      logic       alu_nibble_carry;
      logic       flags_we;
      logic [7:0] flags_wdata;
      logic       bank_we;
      logic       low_we;
      logic [7:0] ptr_wdata;
      logic       save;
      logic       restore;
   } caf_core_req_t;

   // State seen by the core
   typedef struct packed {
      logic [7:0]  accumulator;
      logic [7:0]  program_flags;
      logic [9:0]  instruction_pointer;
      logic [15:0] ram_addr;
   } caf_core_view_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]  accumulator;
      logic [1:0]  reset_cause;
      logic        carry;
      logic        nibble_carry;
      logic        zero;
      logic [9:0]  instruction_pointer;
      logic [7:0]  bank_pointer_reg;
      logic [7:0]  low_pointer_reg;
      logic [7:0]  saved_acc;
      logic [7:0]  saved_flags;
      logic        wb_ack;
      logic [31:0] wb_dat;
   } caf_state_t;

endpackage

/* File: design/caf_core_state.sv */
/*
 Accumulator, flag register, program counter and pointer pair of the
 core, with a classic Wishbone slave onto the system registers.
 Assumes the decoder drives one request per clock and that data memory
 answers a read combinationally in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module caf_core_state
   import caf_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // Wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [9:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // Decoder and ALU side
   input  wire caf_pkg::caf_core_req_t core_req_i,
   output caf_pkg::caf_core_view_t     core_view_o,
   // Data memory behind the indirect port
   input  wire logic [7:0]             ram_rdata_i,
   output logic                        ram_re_o,
   output logic                        ram_we_o,
   output logic      [7:0]             ram_wdata_o,
   // Reset cause and voltage detectors
   input  wire logic [1:0]             reset_cause_i,
   input  wire logic                   high_detector_option_i,
   input  wire logic                   middle_detector_option_i,
   input  wire logic                   supply_below_high_i,
   input  wire logic                   supply_below_low_i
);

   import caf_pkg::*;

   caf_state_t st_ff;
   caf_state_t nxt_st;

   logic       wb_req;
   logic       wb_wr;
   logic [7:0] wb_idx;
   logic [7:0] flags_now;
   logic [7:0] rd_byte;
   logic       skip_true;
   logic [8:0] low_sum;
   logic [7:0] low_diff;
   logic [9:0] ip_cur;

   // True when the index names one of our registers
   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = (idx == IDX_LOW_POINTER) || (idx == IDX_BANK_POINTER) ||
                  (idx == IDX_PROGRAM_FLAGS) || (idx == IDX_IP_LOW) ||
                  (idx == IDX_IP_HIGH) || (idx == IDX_INDIRECT);
   endfunction

   // Pack the visible flag byte; bit 3 reads zero
   function automatic logic [7:0] pack_flags(input caf_state_t s,
                                             input logic hv,
                                             input logic lv);
      logic [7:0] f;
      f = BYTE_ZERO;
      f[FLG_CAUSE_HI:FLG_CAUSE_LO] = s.reset_cause;
      f[FLG_HVD]    = hv;
      f[FLG_LVD]    = lv;
      f[FLG_CARRY]  = s.carry;
      f[FLG_NIBBLE] = s.nibble_carry;
      f[FLG_ZERO]   = s.zero;
      pack_flags = f;
   endfunction

   // One request per bus cycle; ack low in between keeps it single
   assign wb_req = wb_cyc_i && wb_stb_i && !st_ff.wb_ack;
   assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
   assign wb_idx = wb_adr_i[9:2];

   // Detector flags are live and gated by their build option
   assign flags_now = pack_flags(st_ff,
      high_detector_option_i && supply_below_high_i,
      middle_detector_option_i && supply_below_low_i);

   // Indirect port goes straight to data memory
   assign ram_re_o    = wb_req && !wb_we_i && (wb_idx == IDX_INDIRECT);
   assign ram_we_o    = wb_wr && (wb_idx == IDX_INDIRECT);
   assign ram_wdata_o = wb_dat_i[7:0];

   // Read mux; the accumulator has no index here
   always_comb
   begin
      rd_byte = BYTE_ZERO;
      unique case (wb_idx)
         IDX_LOW_POINTER:   rd_byte = st_ff.low_pointer_reg;
         IDX_BANK_POINTER:  rd_byte = st_ff.bank_pointer_reg;
         IDX_PROGRAM_FLAGS: rd_byte = flags_now;
         IDX_IP_LOW:        rd_byte = st_ff.instruction_pointer[7:0];
         IDX_IP_HIGH:       rd_byte = {6'h00, st_ff.instruction_pointer[9:8]};
         IDX_INDIRECT:      rd_byte = ram_rdata_i;
         default:           rd_byte = BYTE_ZERO;
      endcase
   end

   // Skip condition of the current instruction
   always_comb
   begin
      skip_true = 1'b0;
      unique case (core_req_i.skip)
         CAF_SK_COMPARE:   skip_true = (st_ff.accumulator == core_req_i.operand);
         CAF_SK_INCREMENT: skip_true = (core_req_i.dest_old == BYTE_FULL);
         CAF_SK_DECREMENT: skip_true = (core_req_i.dest_old == BYTE_ZERO);
         CAF_SK_BIT_CLEAR: skip_true = !core_req_i.tested_bit;
         CAF_SK_BIT_SET:   skip_true = core_req_i.tested_bit;
         default:          skip_true = 1'b0;
      endcase
   end

   // Low-byte arithmetic for computed jumps
   assign ip_cur   = st_ff.instruction_pointer;
   assign low_sum  = {1'b0, ip_cur[7:0]} + {1'b0, st_ff.accumulator} +
                     {8'h00, core_req_i.add_carry_in};
   assign low_diff = ip_cur[7:0] - st_ff.accumulator;

   // Next state
   always_comb
   begin
      nxt_st = st_ff;

      // Bus answer: one ack per request, unmapped reads give zero
      nxt_st.wb_ack = wb_req;
      nxt_st.wb_dat = st_ff.wb_dat;
      if (wb_req)
      begin
         nxt_st.wb_dat = {24'h000000, is_mapped(wb_idx) ? rd_byte : BYTE_ZERO};
      end

      // Accumulator load from ALU or memory path
      if (core_req_i.acc_we)
      begin
         nxt_st.accumulator = core_req_i.acc_wdata;
      end

      // Hidden copies are taken only on explicit request
      if (core_req_i.save)
      begin
         nxt_st.saved_acc   = st_ff.accumulator;
         nxt_st.saved_flags = flags_now;
      end

      // Flags from the ALU result
      if (core_req_i.alu_flag_we)
      begin
         nxt_st.carry        = core_req_i.alu_carry;
         nxt_st.nibble_carry = core_req_i.alu_nibble_carry;
         nxt_st.zero = (core_req_i.alu_result == BYTE_ZERO);
      end

      // Restore then direct writes override the ALU update
      if (core_req_i.restore)
      begin
         nxt_st.accumulator  = st_ff.saved_acc;
         nxt_st.reset_cause  = st_ff.saved_flags[FLG_CAUSE_HI:FLG_CAUSE_LO];
         nxt_st.carry        = st_ff.saved_flags[FLG_CARRY];
         nxt_st.nibble_carry = st_ff.saved_flags[FLG_NIBBLE];
         nxt_st.zero         = st_ff.saved_flags[FLG_ZERO];
      end
      if (core_req_i.flags_we)
      begin
         nxt_st.reset_cause  = core_req_i.flags_wdata[FLG_CAUSE_HI:FLG_CAUSE_LO];
         nxt_st.carry        = core_req_i.flags_wdata[FLG_CARRY];
         nxt_st.nibble_carry = core_req_i.flags_wdata[FLG_NIBBLE];
         nxt_st.zero         = core_req_i.flags_wdata[FLG_ZERO];
      end

      // Pointer writes from instructions
      if (core_req_i.bank_we)
      begin
         nxt_st.bank_pointer_reg = core_req_i.ptr_wdata;
      end
      if (core_req_i.low_we)
      begin
         nxt_st.low_pointer_reg = core_req_i.ptr_wdata;
      end

      // Program counter; ten-bit sums wrap on their own
      unique case (core_req_i.ip_op)
         CAF_IP_HOLD: nxt_st.instruction_pointer = ip_cur;
         CAF_IP_NEXT: nxt_st.instruction_pointer = ip_cur + IP_STEP;
         CAF_IP_SKIP: nxt_st.instruction_pointer =
            ip_cur + (skip_true ? IP_SKIP_STEP : IP_STEP);
         CAF_IP_JUMP: nxt_st.instruction_pointer = core_req_i.jump_addr;
         CAF_IP_LOW_MOVE: nxt_st.instruction_pointer =
            {ip_cur[9:8], st_ff.accumulator};
         CAF_IP_LOW_ADD: nxt_st.instruction_pointer =
            {ip_cur[9:8] + {1'b0, low_sum[8]}, low_sum[7:0]};
         CAF_IP_LOW_SUB: nxt_st.instruction_pointer =
            {ip_cur[9:8], low_diff};
         default: nxt_st.instruction_pointer = ip_cur;
      endcase

      // Bus writes last, so software wins a same-cycle collision
      if (wb_wr)
      begin
         unique case (wb_idx)
            IDX_LOW_POINTER:  nxt_st.low_pointer_reg = wb_dat_i[7:0];
            IDX_BANK_POINTER: nxt_st.bank_pointer_reg = wb_dat_i[7:0];
            IDX_PROGRAM_FLAGS:
            begin
               // Voltage bits are read-only and simply not stored
               nxt_st.reset_cause  = wb_dat_i[FLG_CAUSE_HI:FLG_CAUSE_LO];
               nxt_st.carry        = wb_dat_i[FLG_CARRY];
               nxt_st.nibble_carry = wb_dat_i[FLG_NIBBLE];
               nxt_st.zero         = wb_dat_i[FLG_ZERO];
            end
            IDX_IP_LOW: nxt_st.instruction_pointer[7:0] = wb_dat_i[7:0];
            IDX_IP_HIGH: nxt_st.instruction_pointer[9:8] = wb_dat_i[1:0];
            default: nxt_st.instruction_pointer = nxt_st.instruction_pointer;
         endcase
      end
   end

   // State register; reset cause is sampled while reset is held
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff                     <= '0;
         st_ff.reset_cause         <= reset_cause_i;
         st_ff.instruction_pointer <= IP_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   assign wb_ack_o = st_ff.wb_ack;
   assign wb_dat_o = st_ff.wb_dat;
   assign core_view_o.accumulator         = st_ff.accumulator;
   assign core_view_o.program_flags       = flags_now;
   assign core_view_o.instruction_pointer = st_ff.instruction_pointer;
   assign core_view_o.ram_addr =
      {st_ff.bank_pointer_reg, st_ff.low_pointer_reg};

endmodule

`default_nettype wire

/* File: sim/caf_core_state_asserts.sv */
/*
 Checker for the core state block: counter steps, flag sources, bus ack.
 Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module caf_core_state_asserts
(
   // Clock, reset and bus
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire logic                    wb_cyc_i,
   input wire logic                    wb_stb_i,
   input wire logic                    wb_we_i,
   input wire logic                    wb_ack_o,
   input wire logic [1:0]              reset_cause_i,
   // Core side
   input wire caf_pkg::caf_core_req_t  core_req_i,
   input wire caf_pkg::caf_core_view_t core_view_o
);
   import caf_pkg::*;
   logic [9:0] ip;
   logic [9:0] add_exp;
   logic [7:0] flg;
   logic [2:0] fw;
   logic [1:0] hi;
   logic       wr;
   // Bus writes override the core, so they mask the core checks
   assign ip = core_view_o.instruction_pointer;
   assign hi = ip[9:8];
   assign flg = core_view_o.program_flags;
   assign fw = core_req_i.flags_wdata[2:0];
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i;
   assign add_exp = ip + {2'b00, core_view_o.accumulator} + {9'h000, core_req_i.add_carry_in};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_ip_step:
      assert property (core_req_i.ip_op == CAF_IP_NEXT && !wr |=> ip == $past(ip) + IP_STEP)
      else $error("counter did not step by one");
   chk_cmp_skip:
      assert property (core_req_i.ip_op == CAF_IP_SKIP && core_req_i.skip == CAF_SK_COMPARE
         && core_req_i.operand == core_view_o.accumulator && !wr
         |=> ip == $past(ip) + IP_SKIP_STEP)
      else $error("compare skip did not step by two");
   chk_low_add:
      assert property (core_req_i.ip_op == CAF_IP_LOW_ADD && !wr |=> ip == $past(add_exp))
      else $error("low byte add did not carry into high byte");
   chk_low_sub:
      assert property (core_req_i.ip_op == CAF_IP_LOW_SUB && !wr |=> hi == $past(hi))
      else $error("low byte subtract changed high byte");
   chk_low_move:
      assert property (core_req_i.ip_op == CAF_IP_LOW_MOVE && !wr
         |=> ip == {$past(hi), $past(core_view_o.accumulator)})
      else $error("low byte move left the page");
   chk_zero_flag:
      assert property (core_req_i.alu_flag_we && !core_req_i.flags_we && !core_req_i.restore
         && !wr |=> flg[0] == ($past(core_req_i.alu_result) == BYTE_ZERO))
      else $error("zero flag does not follow result");
   chk_flag_write:
      assert property (core_req_i.flags_we && !wr |=> flg[2:0] == $past(fw))
      else $error("direct flag write lost");
   chk_reset_state:
      assert property ($fell(rst_i) |-> ip == IP_RESET && flg[7:6] == $past(reset_cause_i))
      else $error("state after reset wrong");
   chk_ack_pulse:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single pulse");

   // Main scenarios reached
   cover property (core_req_i.ip_op == CAF_IP_SKIP);
   cover property (core_req_i.ip_op == CAF_IP_LOW_ADD);
   cover property (wr && wb_ack_o);
endmodule

bind caf_core_state caf_core_state_asserts i_chk (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
   .reset_cause_i, .core_req_i, .core_view_o
);
`default_nettype wire

/* File: sim/caf_mem_model.sv */
/*
 Data memory model behind the indirect port.
 Assumes a read is answered in the cycle of its strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module caf_mem_model
(
   // Clock
   input  wire logic        clk_i,
   // Memory port
   input  wire logic [15:0] addr_i,
   input  wire logic        re_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o
);
   logic [7:0] mem_ff [0:511];
   logic [7:0] junk_ff = 8'h5a;
   // Low bank bit over location byte; idle data toggles so stale reads fail
   assign rdata_o = re_i ? mem_ff[addr_i[8:0]] : junk_ff;
   // Write port
   always @(posedge clk_i)
   begin
      junk_ff <= ~junk_ff;
      if (we_i)
      begin
         mem_ff[addr_i[8:0]] <= wdata_i;
      end
   end
endmodule
`default_nettype wire

/* File: sim/caf_core_state_tb.sv */
/*
 Bench for the core state block: bus registers, pointers, indirect port,
 counter steps, flags, save and restore. Assumes the memory model.
*/
`timescale 1ns/100ps
`default_nettype none
module caf_core_state_tb;
   import caf_pkg::*;
   logic           clk_i = 1'b0;
   logic           rst_i = 1'b1;
   logic           cyc = 1'b0;
   logic           we = 1'b0;
   logic [9:0]     adr = 10'h000;
   logic [31:0]    dat = 32'h0;
   logic [31:0]    rdat;
   logic [31:0]    got;
   logic           ack;
   logic [3:0]     det = 4'h0;
   logic [1:0]     cause = 2'b10;
   logic [7:0]     rram;
   logic [7:0]     wram;
   logic           re;
   logic           wen;
   caf_core_req_t  req;
   caf_core_req_t  idle;
   caf_core_view_t view;
   int             fail_count = 0;
   int             num_checks = 0;
   int             cycles = 0;

   // Clock at 200 MHz
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end

   // Block under test; byte enables stay fixed, reset cause is driven
   caf_core_state i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .core_req_i(req), .core_view_o(view), .ram_rdata_i(rram), .ram_re_o(re),
      .ram_we_o(wen), .ram_wdata_o(wram), .reset_cause_i(cause),
      .high_detector_option_i(det[3]), .supply_below_high_i(det[2]),
      .middle_detector_option_i(det[1]), .supply_below_low_i(det[0])
   );
   caf_mem_model i_mem (
      .clk_i(clk_i), .addr_i(view.ram_addr), .re_i(re), .we_i(wen),
      .wdata_i(wram), .rdata_o(rram)
   );

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Cut a hang short
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fail_count++;
         summarize();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One classic cycle; held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(nm, got, {24'h0, exp});
   endtask

   // One core request, then idle; view is sampled once settled
   task automatic op(input caf_core_req_t r);
      @(posedge clk_i);
      req <= r;
      @(posedge clk_i);
      req <= idle;
      @(negedge clk_i);
   endtask

   task automatic ipop(input caf_ip_op_t o, input caf_skip_t s, input logic [9:0] ja,
                       input logic [7:0] dv, input logic [9:0] exp);
      caf_core_req_t r;
      r = idle;
      r.ip_op = o;
      r.skip = s;
      r.jump_addr = ja;
      r.operand = dv;
      r.dest_old = dv;
      r.tested_bit = dv[0];
      op(r);
      check("ip", {22'h0, view.instruction_pointer}, {22'h0, exp});
   endtask

   task automatic set_accum(input logic [7:0] d);
      caf_core_req_t r;
      r = idle;
      r.acc_we = 1'b1;
      r.acc_wdata = d;
      op(r);
      check("accum", {24'h0, view.accumulator}, {24'h0, d});
   endtask

   task automatic t_regs();
      rd("flags", 8'h86, 8'h80);
      rd("ip high", 8'hcf, 8'h00);
      bus(1'b1, 8'h86, 8'hff);
      rd("flags", 8'h86, 8'hc7);
      det <= 4'b1101;
      rd("flags", 8'h86, 8'he7);
      det <= 4'b0111;
      rd("flags", 8'h86, 8'hd7);
      rd("unmapped", 8'h85, 8'h00);
   endtask

   task automatic t_pointers();
      bus(1'b1, 8'h84, 8'h01);
      bus(1'b1, 8'h83, 8'h26);
      bus(1'b1, 8'he7, 8'ha5);
      bus(1'b1, 8'h83, 8'h25);
      check("ram addr", {16'h0, view.ram_addr}, 32'h0125);
      bus(1'b1, 8'he7, 8'h5a);
      rd("indirect", 8'he7, 8'h5a);
      rd("low ptr", 8'h83, 8'h25);
      rd("bank ptr", 8'h84, 8'h01);
      // Moving the pointer must reach the other byte, not a cell of the port
      bus(1'b1, 8'h83, 8'h26);
      rd("indirect other", 8'he7, 8'ha5);
   endtask

   task automatic t_skips();
      caf_skip_t  fam [5] = '{CAF_SK_COMPARE, CAF_SK_INCREMENT, CAF_SK_DECREMENT,
                              CAF_SK_BIT_CLEAR, CAF_SK_BIT_SET};
      logic [7:0] hit [5] = '{8'h12, 8'hff, 8'h00, 8'h00, 8'h01};
      logic [9:0] e;
      e = 10'h100;
      set_accum(8'h12);
      ipop(CAF_IP_JUMP, CAF_SK_COMPARE, e, 8'h00, e);
      for (int i = 0; i < 5; i++)
      begin
         e = e + IP_SKIP_STEP;
         ipop(CAF_IP_SKIP, fam[i], 10'h0, hit[i], e);
         e = e + IP_STEP;
         ipop(CAF_IP_SKIP, fam[i], 10'h0, hit[i] ^ 8'h01, e);
      end
      ipop(CAF_IP_JUMP, CAF_SK_COMPARE, 10'h3fe, 8'h00, 10'h3fe);
      ipop(CAF_IP_NEXT, CAF_SK_COMPARE, 10'h0, 8'h00, 10'h3ff);
      ipop(CAF_IP_NEXT, CAF_SK_COMPARE, 10'h0, 8'h00, 10'h000);
      ipop(CAF_IP_JUMP, CAF_SK_COMPARE, 10'h3fe, 8'h00, 10'h3fe);
      ipop(CAF_IP_SKIP, CAF_SK_BIT_SET, 10'h0, 8'h01, 10'h000);
   endtask

   task automatic t_low_byte();
      ipop(CAF_IP_JUMP, CAF_SK_COMPARE, 10'h1f0, 8'h00, 10'h1f0);
      set_accum(8'h20);
      ipop(CAF_IP_LOW_ADD, CAF_SK_COMPARE, 10'h0, 8'h00, 10'h210);
      ipop(CAF_IP_LOW_SUB, CAF_SK_COMPARE, 10'h0, 8'h00, 10'h2f0);
      ipop(CAF_IP_JUMP, CAF_SK_COMPARE, 10'h323, 8'h00, 10'h323);
      set_accum(8'h28);
      ipop(CAF_IP_LOW_MOVE, CAF_SK_COMPARE, 10'h0, 8'h00, 10'h328);
      bus(1'b1, 8'hce, 8'h44);
      check("ip", {22'h0, view.instruction_pointer}, 32'h344);
      bus(1'b1, 8'hcf, 8'h01);
      rd("ip high", 8'hcf, 8'h01);
      rd("ip low", 8'hce, 8'h44);
   endtask

   task automatic t_flags_save();
      caf_core_req_t r;
      r = idle;
      r.alu_flag_we = 1'b1;
      r.alu_carry = 1'b1;
      op(r);
      check("alu flags", {29'h0, view.program_flags[2:0]}, 32'h5);
      r.alu_result = 8'h01;
      r.alu_carry = 1'b0;
      r.alu_nibble_carry = 1'b1;
      op(r);
      check("alu flags", {29'h0, view.program_flags[2:0]}, 32'h2);
      r.flags_we = 1'b1;
      r.flags_wdata = 8'h06;
      op(r);
      check("flag write", {29'h0, view.program_flags[2:0]}, 32'h6);
      set_accum(8'h33);
      r = idle;
      r.save = 1'b1;
      op(r);
      r = idle;
      r.alu_flag_we = 1'b1;
      r.alu_result = 8'h01;
      r.acc_we = 1'b1;
      op(r);
      r = idle;
      r.restore = 1'b1;
      op(r);
      check("accum back", {24'h0, view.accumulator}, 32'h33);
      check("flags back", {29'h0, view.program_flags[2:0]}, 32'h6);
   endtask

   // Second reset mid-run with another cause; the new cause must be captured
   task automatic t_reset();
      @(posedge clk_i);
      cause <= CAUSE_PIN;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check("ip", {22'h0, view.instruction_pointer}, {22'h0, IP_RESET});
      rd("flags", 8'h86, 8'hd0);
   endtask

   // Reset for 12 cycles, then each scenario in turn
   initial
   begin
      idle = '0;
      idle.ip_op = CAF_IP_HOLD;
      idle.skip = CAF_SK_COMPARE;
      req = idle;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_pointers();
      t_skips();
      t_low_byte();
      t_flags_save();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
